/* File: logic/cable_drop_compensation.sv */
// Sink-side cable drop compensation supervisor
// ==========================================================
// Function
// - After request negotiated and switch on, monitor output rail voltage until it recovers or compensation fails.
// - Start compensation when rail is below selected voltage times 0.94.
// - Fixed contract: re-request the next higher fixed object position.
// - Fixed contract: total raise never exceeds 4.0 V above original request.
// - Programmable contract: each iteration raises request 0.1 V and resends.
// - Programmable contract: cumulative raise capped at 1.3 V, then stop.
// - No higher object or cap exceeded: fail, keep the last request sent.
// - Negotiation failure enters non-PD operating mode.
// - Non-PD mode turns switch on, charging, 5 V minimum request.
// - Charging with output on drives a four-second breathing LED.
module cable_drop_compensation #(
    parameter longint unsigned BREATH_CYCLES = cdc_pkg::BREATH_CYC,
    parameter int unsigned SETTLE_CYCLES = cdc_pkg::SETTLE_CYC,
    parameter int unsigned FIXED_DEPTH = 7
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    // Selection and rail measurement (millivolts)
    input wire logic [15:0] I_VOLTAGE_SELECT_INPUT,
    input wire logic [15:0] I_OUTPUT_RAIL,
    // Source capabilities: fixed object table load
    input wire logic I_CAP_WR,
    input wire logic [2:0] I_CAP_POS,
    input wire logic [15:0] I_CAP_MV,
    // Negotiation result from policy engine
    input wire logic I_NEG_DONE,
    input wire logic I_NEG_FAIL,
    input wire logic I_NEG_PPS,
    input wire logic [2:0] I_NEG_POS,
    input wire logic [15:0] I_NEG_MV,
    input wire logic I_REQ_ACK,
    // Outputs
    output logic O_SWITCH_GATE_DRIVE,
    output logic O_REQ_VALID,
    output logic [15:0] O_ADJUSTED_REQUEST_VOLTAGE,
    output logic [2:0] O_REQ_POS,
    output logic O_REQ_PPS,
    output logic O_NON_PD,
    output logic O_CHARGING,
    output logic O_COMP_FAIL,
    output logic O_COMP_DONE,
    output logic O_LED
);
    // ==========================================================
    // Types and state
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_CHECK,
        ST_LOOKUP,
        ST_WAIT_RD,
        ST_REQ,
        ST_HOLD
    } state_t;

    state_t state_q;
    cdc_pkg::power_req_t orig_q;
    cdc_pkg::power_req_t cur_q;
    logic [15:0] settle_q;
    logic [15:0] fixed_mv;
    logic [2:0] rd_pos;
    logic low_rail;

    // Rail low test: rail*100 < voltage_select_input*94, done in 32 bits
    function automatic logic below_94(input logic [15:0] rail, input logic [15:0] voltage_select_input);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = 32'(rail) * 32'(cdc_pkg::PCT_DEN);
        rhs = 32'(voltage_select_input) * 32'(cdc_pkg::PCT_NUM);
        return lhs < rhs;
    endfunction : below_94

    assign low_rail = below_94(I_OUTPUT_RAIL, I_VOLTAGE_SELECT_INPUT);
    assign rd_pos = cur_q.fixed_pos + 3'h1;

    fixed_table #(
        .DEPTH(FIXED_DEPTH)
    ) u_table (
        .i_clk(I_CORE_CLK),
        .i_wr(I_CAP_WR),
        .i_wr_pos(I_CAP_POS),
        .i_wr_mv(I_CAP_MV),
        .i_rd_pos(rd_pos),
        .o_rd_mv(fixed_mv)
    );

    // ==========================================================
    // Supervision sequence
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            state_q <= ST_IDLE;
            orig_q <= '{16'h0000, 3'h0, cdc_pkg::OBJ_NONE};
            cur_q <= '{16'h0000, 3'h0, cdc_pkg::OBJ_NONE};
            settle_q <= cdc_pkg::SETTLE_RST;
            O_SWITCH_GATE_DRIVE <= 1'b0;
            O_REQ_VALID <= 1'b0;
            O_NON_PD <= 1'b0;
            O_CHARGING <= 1'b0;
            O_COMP_FAIL <= 1'b0;
            O_COMP_DONE <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (I_NEG_FAIL) begin
                        O_NON_PD <= 1'b1;
                        O_SWITCH_GATE_DRIVE <= 1'b1;
                        O_CHARGING <= 1'b1;
                        cur_q <= '{cdc_pkg::NONPD_MIN_MV, 3'h0, cdc_pkg::OBJ_NONE};
                        state_q <= ST_HOLD;
                    end else if (I_NEG_DONE) begin
                        orig_q <= '{I_NEG_MV, I_NEG_POS,
                                    I_NEG_PPS ? cdc_pkg::OBJ_PPS : cdc_pkg::OBJ_FIXED};
                        cur_q <= '{I_NEG_MV, I_NEG_POS,
                                   I_NEG_PPS ? cdc_pkg::OBJ_PPS : cdc_pkg::OBJ_FIXED};
                        O_SWITCH_GATE_DRIVE <= 1'b1;
                        O_CHARGING <= 1'b1;
                        settle_q <= cdc_pkg::SETTLE_RST;
                        state_q <= ST_SETTLE;
                    end
                end
                // Let the rail settle after each request so one sag is not counted twice
                ST_SETTLE: begin
                    if (32'(settle_q) >= SETTLE_CYCLES) begin
                        state_q <= ST_CHECK;
                    end else begin
                        settle_q <= settle_q + 16'h0001;
                    end
                end
                ST_CHECK: begin
                    if (!low_rail) begin
                        O_COMP_DONE <= 1'b1;
                        state_q <= ST_HOLD;
                    end else if (cur_q.kind == cdc_pkg::OBJ_PPS) begin
                        if (cur_q.volt_mv + cdc_pkg::PPS_STEP_MV
                            > orig_q.volt_mv + cdc_pkg::PPS_CAP_MV) begin
                            O_COMP_FAIL <= 1'b1;
                            state_q <= ST_HOLD;
                        end else begin
                            cur_q.volt_mv <= cur_q.volt_mv + cdc_pkg::PPS_STEP_MV;
                            state_q <= ST_REQ;
                        end
                    end else begin
                        state_q <= ST_LOOKUP;
                    end
                end
                ST_LOOKUP: begin
                    state_q <= ST_WAIT_RD;
                end
                ST_WAIT_RD: begin
                    if (cur_q.fixed_pos >= cdc_pkg::FIXED_POS_MAX || fixed_mv <= cur_q.volt_mv
                        || fixed_mv > orig_q.volt_mv + cdc_pkg::FIXED_CAP_MV) begin
                        O_COMP_FAIL <= 1'b1;
                        state_q <= ST_HOLD;
                    end else begin
                        cur_q.volt_mv <= fixed_mv;
                        cur_q.fixed_pos <= rd_pos;
                        state_q <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    O_REQ_VALID <= 1'b1;
                    if (O_REQ_VALID && I_REQ_ACK) begin
                        O_REQ_VALID <= 1'b0;
                        settle_q <= cdc_pkg::SETTLE_RST;
                        state_q <= ST_SETTLE;
                    end
                end
                ST_HOLD: begin
                    state_q <= ST_HOLD;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Request outputs mirror the current contract
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_ADJUSTED_REQUEST_VOLTAGE <= 16'h0000;
            O_REQ_POS <= 3'h0;
            O_REQ_PPS <= 1'b0;
        end else begin
            O_ADJUSTED_REQUEST_VOLTAGE <= cur_q.volt_mv;
            O_REQ_POS <= cur_q.fixed_pos;
            O_REQ_PPS <= (cur_q.kind == cdc_pkg::OBJ_PPS);
        end
    end

    // ==========================================================
    // Breathing LED: triangle brightness into a PWM
    localparam int unsigned BR_W = $clog2(BREATH_CYCLES + 1);
    logic [BR_W-1:0] br_q;
    logic [7:0] pwm_q;
    logic [7:0] level;
    logic [BR_W-1:0] half;
    logic [63:0] ramp;

    // Scaling runs in 64 bits: a four-second count times 255 overflows 32 bits
    assign half = BR_W'(BREATH_CYCLES / 2);
    assign ramp = (br_q < half) ? 64'(br_q) : 64'(BREATH_CYCLES) - 64'(br_q);
    assign level = 8'((ramp * 64'h00FF) / 64'(half));

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST || !(O_CHARGING && O_SWITCH_GATE_DRIVE)) begin
            br_q <= '0;
            pwm_q <= 8'h00;
            O_LED <= 1'b0;
        end else begin
            br_q <= (64'(br_q) >= BREATH_CYCLES - 1) ? '0 : br_q + 1'b1;
            pwm_q <= pwm_q + 8'h01;
            O_LED <= (pwm_q < level);
        end
    end

    // ==========================================================
    // Checks
    sequence s_req_hs;
        O_REQ_VALID && I_REQ_ACK;
    endsequence

    pps_cap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        cur_q.kind == cdc_pkg::OBJ_PPS |->
        cur_q.volt_mv <= orig_q.volt_mv + cdc_pkg::PPS_CAP_MV)
        else $error("programmable raise beyond cap");
    fixed_cap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        cur_q.kind == cdc_pkg::OBJ_FIXED |->
        cur_q.volt_mv <= orig_q.volt_mv + cdc_pkg::FIXED_CAP_MV)
        else $error("fixed raise beyond cap");
    pps_step_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        state_q == ST_CHECK && low_rail && cur_q.kind == cdc_pkg::OBJ_PPS && !O_COMP_FAIL
        ##1 state_q == ST_REQ |-> cur_q.volt_mv == $past(cur_q.volt_mv) + cdc_pkg::PPS_STEP_MV)
        else $error("programmable step not 0.1 V");
    stop_good_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        state_q == ST_CHECK && !low_rail |=> state_q == ST_HOLD && O_COMP_DONE)
        else $error("increment after rail recovered");
    nonpd_on_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        state_q == ST_IDLE && I_NEG_FAIL |=>
        O_NON_PD && O_SWITCH_GATE_DRIVE && O_CHARGING)
        else $error("non-PD mode not entered");
    fixed_next_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        state_q == ST_WAIT_RD ##1 state_q == ST_REQ |->
        cur_q.fixed_pos == $past(cur_q.fixed_pos) + 3'h1)
        else $error("fixed step not next position");
    fail_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        $rose(O_COMP_FAIL) |-> state_q == ST_HOLD ##1 $stable(cur_q))
        else $error("request changed after failure");
    hs_settle_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        ((state_q == ST_REQ) and s_req_hs) |=> state_q == ST_SETTLE && !O_REQ_VALID)
        else $error("monitoring not resumed after request");
    led_off_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        !O_CHARGING |=> !O_LED)
        else $error("LED lit outside charging");
    start_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        state_q == ST_CHECK && low_rail && !O_COMP_DONE |=>
        state_q inside {ST_REQ, ST_LOOKUP, ST_HOLD})
        else $error("compensation not started on low rail");
endmodule : cable_drop_compensation

/* File: logic/cdc_pkg.sv */
// Package of constants and carrier types for cable drop compensation
package cdc_pkg;
    // ==========================================================
    // Voltage units: millivolts, 16 bits
    localparam int unsigned MV_W = 16;
    localparam logic [15:0] PPS_STEP_MV = 16'h0064;
    localparam logic [15:0] PPS_CAP_MV = 16'h0514;
    localparam logic [15:0] FIXED_CAP_MV = 16'h0FA0;
    localparam logic [15:0] NONPD_MIN_MV = 16'h1388;
    localparam logic [15:0] PCT_NUM = 16'h005E;
    localparam logic [15:0] PCT_DEN = 16'h0064;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BREATH_MS = 4000;
    localparam longint unsigned BREATH_CYC = longint'(BREATH_MS) * CLK_HZ / 1000;
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam logic [15:0] SETTLE_RST = 16'h0000;
    localparam int unsigned FIXED_POS_W = 3;
    localparam logic [2:0] FIXED_POS_MAX = 3'h6;

    typedef enum logic [1:0] {
        OBJ_FIXED,
        OBJ_PPS,
        OBJ_NONE
    } obj_kind_t;

    typedef struct packed {
        logic [15:0] volt_mv;
        logic [2:0] fixed_pos;
        obj_kind_t kind;
    } power_req_t;
endpackage : cdc_pkg

/* File: logic/fixed_table.sv */
// Small memory holding source fixed object voltages by position
module fixed_table #(
    parameter int unsigned DEPTH = 7
) (
    // Clock only
    input wire logic i_clk,
    // Write port
    input wire logic i_wr,
    input wire logic [2:0] i_wr_pos,
    input wire logic [15:0] i_wr_mv,
    // Read port
    input wire logic [2:0] i_rd_pos,
    output logic [15:0] o_rd_mv
);
    // ==========================================================
    // Storage
    logic [15:0] mem_q [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr && (32'(i_wr_pos) < DEPTH)) begin
            mem_q[i_wr_pos] <= i_wr_mv;
        end
    end

    // Registered read; out of range reads as zero, meaning no object
    always_ff @(posedge i_clk) begin
        if (32'(i_rd_pos) < DEPTH) begin
            o_rd_mv <= mem_q[i_rd_pos];
        end else begin
            o_rd_mv <= 16'h0000;
        end
    end
endmodule : fixed_table

/* File: verification/src_policy_model.sv */
// Behavioural source policy engine with cable drop for the compensation bench
module src_policy_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Request from the sink
    input wire logic i_req_valid,
    input wire logic [15:0] i_req_mv,
    input wire logic i_gate,
    // Test controls
    input wire logic [7:0] i_ack_delay,
    input wire logic [15:0] i_drop_mv,
    // Answer and rail
    output logic o_ack,
    output logic [15:0] o_rail_mv
);
    // ==========================================================
    // Acceptance: one-cycle pulse while the request is held, slow or prompt
    logic [7:0] wait_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_req_valid || o_ack) begin
            wait_q <= 8'h00;
            o_ack <= 1'b0;
        end else if (wait_q >= i_ack_delay) begin
            o_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
    // ==========================================================
    // Rail: supply follows the request, cable subtracts, open switch reads zero
    assign o_rail_mv = i_gate ? (i_req_mv - i_drop_mv) : 16'h0000;
endmodule : src_policy_model

/* File: verification/tb_cable_drop_compensation.sv */
// Self-checking bench for the cable drop compensation supervisor
module tb_cable_drop_compensation;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] voltage_select_input = 16'h1388;
    logic [15:0] rail;
    logic cap_wr = 1'b0;
    logic [2:0] cap_pos = 3'h0;
    logic [15:0] cap_mv = 16'h0000;
    logic neg_done = 1'b0;
    logic neg_fail = 1'b0;
    logic neg_pps = 1'b0;
    logic [2:0] neg_pos = 3'h0;
    logic [15:0] neg_mv = 16'h0000;
    logic ack;
    logic gate, req_valid, req_pps, non_pd, charging, comp_fail, comp_done, led;
    logic [15:0] adj;
    logic [2:0] req_pos;
    logic [7:0] ack_delay = 8'h00;
    logic [15:0] drop_mv = 16'h0000;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    // ==========================================================
    // Instances
    cable_drop_compensation #(.BREATH_CYCLES(64), .SETTLE_CYCLES(4), .FIXED_DEPTH(7)) i_dut (
        .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_VOLTAGE_SELECT_INPUT(voltage_select_input),
        .I_OUTPUT_RAIL(rail), .I_CAP_WR(cap_wr), .I_CAP_POS(cap_pos), .I_CAP_MV(cap_mv),
        .I_NEG_DONE(neg_done), .I_NEG_FAIL(neg_fail), .I_NEG_PPS(neg_pps),
        .I_NEG_POS(neg_pos), .I_NEG_MV(neg_mv), .I_REQ_ACK(ack),
        .O_SWITCH_GATE_DRIVE(gate), .O_REQ_VALID(req_valid),
        .O_ADJUSTED_REQUEST_VOLTAGE(adj), .O_REQ_POS(req_pos), .O_REQ_PPS(req_pps),
        .O_NON_PD(non_pd), .O_CHARGING(charging), .O_COMP_FAIL(comp_fail),
        .O_COMP_DONE(comp_done), .O_LED(led));
    src_policy_model i_src (
        .i_clk(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req_mv(adj),
        .i_gate(gate), .i_ack_delay(ack_delay), .i_drop_mv(drop_mv),
        .o_ack(ack), .o_rail_mv(rail));
    // ==========================================================
    // Helpers
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // Timeout is far above the sum of all scenarios
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic do_reset(input int n);
        @(posedge clk) #1 rst = 1'b1;
        repeat (n) @(posedge clk);
        #1 rst = 1'b0;
    endtask : do_reset
    // Entries above position 2 are absent, so every load rewrites the whole table
    task automatic load_tab(input logic [15:0] e1, input logic [15:0] e2);
        for (int p = 0; p < 7; p++) begin
            @(posedge clk) #1 cap_wr = 1'b1;
            cap_pos = 3'(p);
            cap_mv = (p == 0) ? 16'h1388 : (p == 1) ? e1 : (p == 2) ? e2 : 16'h0000;
        end
        @(posedge clk) #1 cap_wr = 1'b0;
    endtask : load_tab
    task automatic negotiate(input logic pps, input logic [15:0] mv);
        @(posedge clk) #1 neg_done = 1'b1;
        neg_pps = pps;
        neg_pos = 3'h0;
        neg_mv = mv;
        @(posedge clk) #1 neg_done = 1'b0;
        for (int i = 0; i < 600 && (comp_done | comp_fail) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(gate & charging, 1'b1, "switch on after negotiation");
    endtask : negotiate
    function automatic int pps_exp(input int vs, input int drop, output logic fail);
        int v;
        v = vs;
        while ((v - drop) * int'(cdc_pkg::PCT_DEN) < vs * int'(cdc_pkg::PCT_NUM) &&
               v + int'(cdc_pkg::PPS_STEP_MV) <= vs + int'(cdc_pkg::PPS_CAP_MV))
            v += int'(cdc_pkg::PPS_STEP_MV);
        fail = ((v - drop) * int'(cdc_pkg::PCT_DEN) < vs * int'(cdc_pkg::PCT_NUM));
        return v;
    endfunction : pps_exp
    // ==========================================================
    // Scenarios
    task automatic t_nonpd(input logic [15:0] vs);
        int hi;
        int lo;
        do_reset(2);
        voltage_select_input = vs;
        repeat (20) @(posedge clk);
        #1 check(led, 1'b0, "led dark before charging");
        neg_fail = 1'b1;
        neg_done = 1'b1;
        @(posedge clk) #1 neg_fail = 1'b0;
        neg_done = 1'b0;
        @(posedge clk) #1 check(non_pd, 1'b1, "non-PD mode");
        check(gate & charging, 1'b1, "switch on and charging");
        @(posedge clk) #1 check(adj, cdc_pkg::NONPD_MIN_MV, "non-PD request");
        // Breathing means both lit and dark phases, neither full light nor dark
        hi = 0;
        lo = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (led === 1'b1) hi++;
            if (led === 1'b0) lo++;
        end
        check(16'(hi > 0 && lo > 0), 16'h0001, "led breathes");
    endtask : t_nonpd
    task automatic t_pps(input int vs, input int drop, input logic [7:0] dly);
        logic fail;
        int v;
        do_reset(2);
        voltage_select_input = 16'(vs);
        drop_mv = 16'(drop);
        ack_delay = dly;
        v = pps_exp(vs, drop, fail);
        negotiate(1'b1, 16'(vs));
        check(adj, 16'(v), "programmable request");
        check(req_pps, 1'b1, "programmable contract");
        check(comp_fail, fail, "programmable cap");
        check(comp_done, !fail, "rail reached threshold");
    endtask : t_pps
    task automatic t_fixed(input logic [15:0] e1, input logic [15:0] e2, input int drop,
                           input logic [2:0] pos, input logic [15:0] mv, input logic fail);
        do_reset(2);
        voltage_select_input = 16'h1388;
        drop_mv = 16'(drop);
        ack_delay = 8'h03;
        load_tab(e1, e2);
        negotiate(1'b0, 16'h1388);
        check(req_pos, pos, "fixed position");
        check(adj, mv, "fixed request");
        check(comp_fail, fail, "fixed failure");
        check(req_valid, 1'b0, "no pending request");
    endtask : t_fixed
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        t_nonpd(16'h1388);
        t_nonpd(16'h2328);
        t_pps(5000, 0, 8'h00);
        t_pps(5000, 1000, 8'h00);
        t_pps(9000, 700, 8'h06);
        t_pps(5000, 2000, 8'h01);
        t_fixed(16'h2328, 16'h2EE0, 1000, 3'h1, 16'h2328, 1'b0);
        t_fixed(16'h2328, 16'h2EE0, 5000, 3'h1, 16'h2328, 1'b1);
        t_fixed(16'h0000, 16'h0000, 1000, 3'h0, 16'h1388, 1'b1);
        test_done();
    end
endmodule : tb_cable_drop_compensation
